// File: sram_host_consts.svh
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
// ==========================================================
// timing figures in ns and derived cycle counts at 200 MHz
// ==========================================================
`define CLK_PERIOD_NS 5
`define T_RC_NS 45
`define T_PWE_NS 35
`define T_SD_NS 25
`define T_HZWE_NS 18
`define T_LZWE_NS 10
// least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC `CYC_UP(`T_RC_NS)
`define WR_CYC `CYC_UP(`T_PWE_NS)
`define TURN_CYC `CYC_UP(`T_HZWE_NS)
`define REC_CYC `CYC_UP(`T_LZWE_NS)
// ==========================================================
// pin idle levels
// ==========================================================
`define IDLE_SEL_N 1'b1
`define IDLE_SEL 1'b0
`define IDLE_WE_N 1'b1
`define IDLE_OE_N 1'b1
`define IDLE_BE_N 2'h3
`endif

// File: sram_host_pkg.sv
package sram_host_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_read = 3'b001,
      st_wr_setup = 3'b010,
      st_write = 3'b011,
      st_recover = 3'b100
   } host_state_e;
   typedef logic [7:0] cyc_cnt_t;
endpackage

// File: cycle_timer.sv
`timescale 1ns/1ps
// ==========================================================
// down counter: load a count, pulse done when it expires
// ==========================================================
module cycle_timer
   import sram_host_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic load_i,
   input wire cyc_cnt_t count_i,
   output logic done_o
);
   cyc_cnt_t cnt_ff;
   logic run_ff;

   // count loaded value down to one, then flag done
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_ff <= 8'h00;
         run_ff <= 1'b0;
      end else if (load_i) begin
         cnt_ff <= count_i;
         run_ff <= 1'b1;
      end else if (run_ff) begin
         cnt_ff <= cnt_ff - 8'h01;
         if (cnt_ff == 8'h01) begin
            run_ff <= 1'b0;
         end
      end
   end

   assign done_o = run_ff && (cnt_ff == 8'h01);
endmodule

// File: sram_host.sv
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_host
   import sram_host_pkg::*;
#(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 16
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic req_i,
   input wire logic req_write_i,
   input wire logic [1:0] req_be_i,
   input wire logic [ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic primary_select_n_o,
   output logic secondary_select_o,
   output logic write_n_o,
   output logic out_enable_n_o,
   output logic upper_byte_enable_n_o,
   output logic lower_byte_enable_n_o,
   output logic [DATA_W-1:0] data_out_o,
   output logic data_oe_o,
   input wire logic [DATA_W-1:0] data_i
);
   localparam cyc_cnt_t RD_N = cyc_cnt_t'(`RD_CYC);
   localparam cyc_cnt_t WR_N = cyc_cnt_t'(`WR_CYC);
   localparam cyc_cnt_t TURN_N = cyc_cnt_t'(`TURN_CYC);
   localparam cyc_cnt_t REC_N = cyc_cnt_t'(`REC_CYC);

   host_state_e state_ff;
   logic [DATA_W-1:0] sync1_ff;
   logic [DATA_W-1:0] sync2_ff;
   logic [1:0] be_ff;
   logic timer_load;
   cyc_cnt_t timer_count;
   logic timer_done;

   // keep byte lanes of a read that were not enabled at zero
   function automatic logic [DATA_W-1:0] lane_mask(
      input logic [DATA_W-1:0] d, input logic [1:0] be);
      lane_mask = {be[1] ? d[DATA_W-1:8] : 8'h00,
                   be[0] ? d[7:0] : 8'h00};
   endfunction

   // ==========================================================
   // pin synchroniser for returned data
   // ==========================================================
   always_ff @(posedge clock_i) begin
      sync1_ff <= data_i;
      sync2_ff <= sync1_ff;
   end

   // ==========================================================
   // sequencing
   // ==========================================================
   // timer loads on every phase entry except recovery after a read
   always_comb begin
      timer_load = 1'b0;
      timer_count = RD_N;
      unique case (state_ff)
         st_idle: begin
            timer_load = req_i && (req_be_i != 2'h0);
            timer_count = req_write_i ? TURN_N : RD_N;
         end
         st_wr_setup: begin
            timer_load = timer_done;
            timer_count = WR_N;
         end
         st_write: begin
            timer_load = timer_done;
            timer_count = REC_N;
         end
         st_read, st_recover: begin
            timer_load = 1'b0;
            timer_count = RD_N;
         end
      endcase
   end

   cycle_timer u_timer (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .load_i(timer_load),
      .count_i(timer_count),
      .done_o(timer_done)
   );

   // state and all pin levels move together
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_ff <= st_idle;
         primary_select_n_o <= `IDLE_SEL_N;
         secondary_select_o <= `IDLE_SEL;
         write_n_o <= `IDLE_WE_N;
         out_enable_n_o <= `IDLE_OE_N;
         {upper_byte_enable_n_o, lower_byte_enable_n_o} <= `IDLE_BE_N;
         data_oe_o <= 1'b0;
         data_out_o <= '0;
         addr_o <= '0;
         be_ff <= 2'h0;
      end else begin
         unique case (state_ff)
            st_idle: begin
               // requests with no enabled lane are dropped
               if (req_i && (req_be_i != 2'h0)) begin
                  // address goes out with the selects
                  addr_o <= req_addr_i;
                  be_ff <= req_be_i;
                  primary_select_n_o <= 1'b0;
                  secondary_select_o <= 1'b1;
                  // enables pick the lanes
                  upper_byte_enable_n_o <= ~req_be_i[1];
                  lower_byte_enable_n_o <= ~req_be_i[0];
                  data_out_o <= req_wdata_i;
                  if (req_write_i) begin
                     // output enable high keeps memory off the bus
                     out_enable_n_o <= 1'b1;
                     state_ff <= st_wr_setup;
                  end else begin
                     write_n_o <= 1'b1;
                     out_enable_n_o <= 1'b0;
                     state_ff <= st_read;
                  end
               end
            end
            st_read: begin
               // hold selects steady until data settles
               if (timer_done) begin
                  primary_select_n_o <= 1'b1;
                  secondary_select_o <= 1'b0;
                  out_enable_n_o <= 1'b1;
                  {upper_byte_enable_n_o, lower_byte_enable_n_o} <= `IDLE_BE_N;
                  state_ff <= st_recover;
               end
            end
            st_wr_setup: begin
               // wait out memory turn-off before driving
               if (timer_done) begin
                  write_n_o <= 1'b0;
                  data_oe_o <= 1'b1;
                  state_ff <= st_write;
               end
            end
            st_write: begin
               // strobe rises first and ends the write; data held
               if (timer_done) begin
                  write_n_o <= 1'b1;
                  state_ff <= st_recover;
               end
            end
            st_recover: begin
               data_oe_o <= 1'b0;
               primary_select_n_o <= 1'b1;
               secondary_select_o <= 1'b0;
               {upper_byte_enable_n_o, lower_byte_enable_n_o} <= `IDLE_BE_N;
               if (timer_done || !data_oe_o) begin
                  state_ff <= st_idle;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // answer to the user side
   // ==========================================================
   // data sampled at end of read; sync adds two cycles, covered by t_rc
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         done_o <= 1'b0;
         rdata_o <= '0;
         busy_o <= 1'b0;
      end else begin
         done_o <= (state_ff == st_read || state_ff == st_write) &&
                   timer_done;
         if (state_ff == st_read && timer_done) begin
            rdata_o <= lane_mask(sync2_ff, be_ff);
         end
         busy_o <= (state_ff != st_idle) || (req_i && req_be_i != 2'h0);
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   chk_read_we_high: assert property (
      (state_ff == st_read) |-> write_n_o) else $error("strobe low in read");
   chk_read_steady: assert property (
      (state_ff == st_read) && $past(state_ff == st_read) |->
      $stable(addr_o) && $stable(primary_select_n_o) && !out_enable_n_o)
      else $error("read pins moved");
   chk_no_contend: assert property (
      data_oe_o |-> out_enable_n_o) else $error("drive with oe low");
   chk_write_oe: assert property (
      !write_n_o |-> out_enable_n_o && data_oe_o)
      else $error("write without drive");
   chk_write_len: assert property (
      $fell(write_n_o) |-> (!write_n_o && data_oe_o)[*7]
      ##1 (write_n_o && data_oe_o) ##1 !data_oe_o)
      else $error("write pulse wrong");
   chk_write_sel: assert property (
      !write_n_o |-> !primary_select_n_o && secondary_select_o &&
      !(upper_byte_enable_n_o && lower_byte_enable_n_o))
      else $error("write not selected");
   chk_idle_desel: assert property (
      (state_ff == st_idle) |-> primary_select_n_o && !secondary_select_o)
      else $error("idle selected");
   chk_sel_drop: assert property (
      $rose(primary_select_n_o) |-> $fell(secondary_select_o) && write_n_o)
      else $error("selects split");
   chk_lane_out: assert property (
      $fell(primary_select_n_o) |->
      upper_byte_enable_n_o == ~be_ff[1] && lower_byte_enable_n_o == ~be_ff[0])
      else $error("lanes wrong");
   chk_read_done: assert property (
      $fell(out_enable_n_o) |-> ##9 done_o) else $error("read late");
   chk_oe_idle: assert property (
      (state_ff == st_wr_setup) |-> out_enable_n_o && !data_oe_o)
      else $error("setup drive");

   cov_read: cover property ($fell(out_enable_n_o) ##[1:20] done_o);
   cov_write: cover property ($fell(write_n_o) ##[1:20] done_o);
   cov_byte_wr: cover property (!write_n_o && upper_byte_enable_n_o);
   cov_b2b: cover property (done_o ##[1:4] $fell(primary_select_n_o));
endmodule

// File: sram_device_model.sv
`timescale 1ns/1ps
// ==========================================================
// behavioural static memory seen from its pins
// ==========================================================
module sram_device_model (
   input wire logic [18:0] addr_i,
   input wire logic primary_select_n_i,
   input wire logic secondary_select_i,
   input wire logic write_n_i,
   input wire logic out_enable_n_i,
   input wire logic upper_byte_enable_n_i,
   input wire logic lower_byte_enable_n_i,
   input wire logic host_drive_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o,
   output logic fault_o
);
   logic [15:0] mem [bit [18:0]];
   logic [15:0] last = 16'h0000;
   logic [15:0] rd;
   logic sel, wr, lo_rd, hi_rd;
   // any inactive select or both enables high means standby
   assign sel = !primary_select_n_i && secondary_select_i
      && !(upper_byte_enable_n_i && lower_byte_enable_n_i);
   assign wr = sel && !write_n_i;
   // lanes drive only in a true read; oe high or strobe low keeps them off
   assign lo_rd = sel && write_n_i && !out_enable_n_i
      && !lower_byte_enable_n_i;
   assign hi_rd = sel && write_n_i && !out_enable_n_i
      && !upper_byte_enable_n_i;
   // level store: whatever is on the pins when the write ends stays
   always @(wr, addr_i, data_i, upper_byte_enable_n_i,
            lower_byte_enable_n_i) begin
      if (wr && !lower_byte_enable_n_i) begin
         mem[addr_i][7:0] = data_i[7:0];
      end
      if (wr && !upper_byte_enable_n_i) begin
         mem[addr_i][15:8] = data_i[15:8];
      end
   end
   // released lanes show the inverse of their last value, not a hold
   always @(addr_i, lo_rd, hi_rd) begin
      rd = mem.exists(addr_i) ? mem[addr_i] : 16'hxxxx;
      if (lo_rd) begin
         data_o[7:0] = rd[7:0];
         last[7:0] = rd[7:0];
      end else begin
         data_o[7:0] = ~last[7:0];
      end
      if (hi_rd) begin
         data_o[15:8] = rd[15:8];
         last[15:8] = rd[15:8];
      end else begin
         data_o[15:8] = ~last[15:8];
      end
   end
   // sticky flag for host misbehaviour on the pins
   initial fault_o = 1'b0;
   always @(host_drive_i, lo_rd, hi_rd) begin
      if (host_drive_i && (lo_rd || hi_rd)) fault_o = 1'b1;
   end
   always @(addr_i) begin
      if (wr) fault_o = 1'b1;
   end
endmodule

// File: sram_host_bench.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the memory host
// ==========================================================
module sram_host_bench;
   import sram_host_pkg::*;
   logic clock_i, sys_rst_i, req_i, req_write_i;
   logic [1:0] req_be_i;
   logic [18:0] req_addr_i, addr_o;
   logic [15:0] req_wdata_i, rdata_o, data_out_o, data_i, mem_data;
   logic busy_o, done_o, primary_select_n_o, secondary_select_o, write_n_o;
   logic out_enable_n_o, upper_byte_enable_n_o, lower_byte_enable_n_o;
   logic data_oe_o, fault;
   int errors = 0;
   int cmp_count = 0;
   // pin level: host wins while it drives, else the memory side
   assign data_i = data_oe_o ? data_out_o : mem_data;
   sram_host sram_host_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .req_i(req_i), .req_write_i(req_write_i), .req_be_i(req_be_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .busy_o(busy_o),
      .done_o(done_o), .rdata_o(rdata_o), .addr_o(addr_o),
      .primary_select_n_o(primary_select_n_o),
      .secondary_select_o(secondary_select_o), .write_n_o(write_n_o),
      .out_enable_n_o(out_enable_n_o),
      .upper_byte_enable_n_o(upper_byte_enable_n_o),
      .lower_byte_enable_n_o(lower_byte_enable_n_o),
      .data_out_o(data_out_o), .data_oe_o(data_oe_o), .data_i(data_i));
   sram_device_model sram_device_model_inst (.addr_i(addr_o),
      .primary_select_n_i(primary_select_n_o),
      .secondary_select_i(secondary_select_o), .write_n_i(write_n_o),
      .out_enable_n_i(out_enable_n_o),
      .upper_byte_enable_n_i(upper_byte_enable_n_o),
      .lower_byte_enable_n_i(lower_byte_enable_n_o),
      .host_drive_i(data_oe_o), .data_i(data_i), .data_o(mem_data),
      .fault_o(fault));
   // 200 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check_word(input string what, input logic [15:0] exp,
                             input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask
   // one request, held for a single edge, then wait for done and idle
   task automatic do_op(input logic w, input logic [1:0] be,
      input logic [18:0] a, input logic [15:0] wd,
      output logic [15:0] rd, output logic seen);
      int n;
      seen = 1'b0;
      rd = 16'hxxxx;
      @(posedge clock_i);
      req_i <= 1'b1;
      req_write_i <= w;
      req_be_i <= be;
      req_addr_i <= a;
      req_wdata_i <= wd;
      @(posedge clock_i);
      req_i <= 1'b0;
      for (n = 0; n < 40 && !seen; n++) begin
         @(posedge clock_i);
         #1;
         if (done_o === 1'b1) begin
            seen = 1'b1;
            rd = rdata_o;
         end
      end
      for (n = 0; n < 10 && busy_o !== 1'b0; n++) begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task automatic t_reset_idle();
      check_bit("primary select", 1'b1, primary_select_n_o);
      check_bit("secondary select", 1'b0, secondary_select_o);
      check_bit("strobe", 1'b1, write_n_o);
      check_bit("host drive", 1'b0, data_oe_o);
   endtask
   // full words at the top of the address range and at address 1
   task automatic t_word();
      logic [15:0] rd;
      logic seen;
      do_op(1'b1, 2'h3, 19'h7ffff, 16'ha5c3, rd, seen);
      check_bit("write done", 1'b1, seen);
      do_op(1'b1, 2'h3, 19'h00001, 16'h1e2d, rd, seen);
      do_op(1'b0, 2'h3, 19'h7ffff, 16'h0000, rd, seen);
      check_word("word read high", 16'ha5c3, rd);
      do_op(1'b0, 2'h3, 19'h00001, 16'h0000, rd, seen);
      check_word("word read low", 16'h1e2d, rd);
   endtask
   // byte writes must leave the other lane alone
   task automatic t_byte_write();
      logic [15:0] rd;
      logic seen;
      do_op(1'b1, 2'h1, 19'h00001, 16'h9977, rd, seen);
      do_op(1'b0, 2'h3, 19'h00001, 16'h0000, rd, seen);
      check_word("lower write", 16'h1e77, rd);
      do_op(1'b1, 2'h2, 19'h00001, 16'h4455, rd, seen);
      do_op(1'b0, 2'h3, 19'h00001, 16'h0000, rd, seen);
      check_word("upper write", 16'h4477, rd);
   endtask
   // single-lane reads return zero on the unused lane
   task automatic t_byte_read();
      logic [15:0] rd;
      logic seen;
      do_op(1'b0, 2'h1, 19'h7ffff, 16'h0000, rd, seen);
      check_word("lower read", 16'h00c3, rd);
      do_op(1'b0, 2'h2, 19'h7ffff, 16'h0000, rd, seen);
      check_word("upper read", 16'ha500, rd);
   endtask
   // no lanes enabled means no cycle at all
   task automatic t_refuse();
      logic [15:0] rd;
      logic seen;
      do_op(1'b1, 2'h0, 19'h00001, 16'hffff, rd, seen);
      check_bit("empty request done", 1'b0, seen);
      check_bit("busy on refusal", 1'b0, busy_o);
      do_op(1'b0, 2'h3, 19'h00001, 16'h0000, rd, seen);
      check_word("after refusal", 16'h4477, rd);
   endtask
   // cut a hang short well past the expected few hundred cycles
   initial begin
      #20000;
      errors++;
      final_report();
   end
   initial begin
      sys_rst_i = 1'b1;
      req_i = 1'b0;
      req_write_i = 1'b0;
      req_be_i = 2'h0;
      req_addr_i = 19'h00000;
      req_wdata_i = 16'h0000;
      repeat (3) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      @(posedge clock_i);
      #1;
      t_reset_idle();
      t_word();
      t_byte_write();
      t_byte_read();
      t_refuse();
      check_bit("pin contention", 1'b0, fault);
      final_report();
   end
endmodule
